// >>> shared/asc_consts.svh
// Constants of the converter serial control port: widths, bit fields, timing
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

`define ASC_WORD_W 10
`define ASC_WRITE_CLOCKS 13
`define ASC_READ_RELEASE 10
`define ASC_CTRL_RESET 10'h000

// Control word fields, bit 9 is a don't care
`define ASC_EXTERNAL_REFERENCE_SELECT 0
`define ASC_TRIGGER_MODE_BIT 1
`define ASC_CHANNEL_LOW 2
`define ASC_CHANNEL_HIGH 3
`define ASC_DIFF_SELECT 4
`define ASC_COMMON_SELECT 5
`define ASC_POWER_DOWN_SELECT_LOW 6
`define ASC_POWER_DOWN_SELECT_HIGH 7
`define ASC_PACKAGE_ADDRESS_BIT 8

// Power-down select decoding
`define ASC_PD_FULL_NOW 2'h0
`define ASC_PD_PARTIAL_EOC 2'h1
`define ASC_PD_FULL_EOC 2'h2
`define ASC_PD_STAY_UP 2'h3

// Timing at a 200 MHz core clock
`define ASC_CLK_MHZ 200
`define ASC_CONV_TIME_NS 2300
`define ASC_CONV_CYCLES ((`ASC_CONV_TIME_NS * `ASC_CLK_MHZ) / 1000)
`define ASC_POWER_UP_NS 1500
`define ASC_POWER_UP_CYCLES ((`ASC_POWER_UP_NS * `ASC_CLK_MHZ) / 1000)
`define ASC_SCLK_HALF_NS 40
`define ASC_SCLK_HALF_CYCLES ((`ASC_SCLK_HALF_NS * `ASC_CLK_MHZ) / 1000)

// Synchroniser lanes and their idle levels
`define ASC_LANE_SCLK 0
`define ASC_LANE_WFS 1
`define ASC_LANE_RFS 2
`define ASC_LANE_DIN 3
`define ASC_LANE_TRIG 4
`define ASC_LANE_PIN 5
`define ASC_SYNC_IDLE 6'h13

`endif

// >>> shared/asc_pkg.sv
// Types shared by both ends of the converter serial control port
package asc_pkg;

    typedef enum logic [1:0] {
        ASC_PWR_FULL_DOWN,
        ASC_PWR_PARTIAL_DOWN,
        ASC_PWR_WAKING,
        ASC_PWR_UP
    } asc_pwr_type;

    typedef enum logic [1:0] {
        ASC_HOST_IDLE,
        ASC_HOST_WRITE,
        ASC_HOST_READ
    } asc_host_state_type;

endpackage : asc_pkg

// >>> shared/asc_link_if.sv
// Serial link between the converter control port and its host
`timescale 1ns/1ps
interface asc_link_if;
    logic sclk;
    logic write_frame_sync;
    logic read_frame_sync;
    logic din;
    logic dout;
    logic dout_oe;
    logic conversion_trigger;
    logic dout_line;

    // Released line reads high, as with a pull-up
    assign dout_line = dout_oe ? dout : 1'b1;

    modport dev (
        input sclk,
        input write_frame_sync,
        input read_frame_sync,
        input din,
        input conversion_trigger,
        output dout,
        output dout_oe
    );

    modport host (
        output sclk,
        output write_frame_sync,
        output read_frame_sync,
        output din,
        output conversion_trigger,
        input dout_line
    );
endinterface : asc_link_if

// >>> core/asc_device.sv
// Converter end: control word capture, result readout, conversion and power control
//
`timescale 1ns/1ps
`include "asc_consts.svh"

// How it works
// - Write frame fall starts ten-bit capture
// - Thirteen clocks per write, extra bits ignored
// - Read ignores clock until read frame rises
// - Read counter clears when read finishes
// - Output changes on rise, input on fall
// - Output released on eleventh rising edge
// - Trigger fall holds sample, starts conversion
// - Trigger level sampled at conversion end
// - Address pin and bit select device
// - Host sets reference bit for external reference
// - Mismatched word dropped, deselects output
// - Ten-bit control register, resets to zero
// - Power-down select bits decoded four ways
module asc_device (
    input wire logic clk, // Core clock, 200 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    asc_link_if.dev link, // Serial link to the host
    input wire logic package_address_pin, // Hardwired package address
    input wire logic [`ASC_WORD_W-1:0] sample_code, // Code from the front end
    output logic [`ASC_WORD_W-1:0] ctrl_word, // Accepted control word
    output logic selected, // Last write matched our address
    output asc_pkg::asc_pwr_type power_state, // Power state
    output logic hold_active, // Track/hold in hold
    output logic result_valid, // One-cycle pulse at conversion end
    output logic [`ASC_WORD_W-1:0] result_word, // Last conversion result
    output logic trigger_at_end // Trigger level seen at conversion end
);
    import asc_pkg::*;

    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] sync3_reg;
    logic [5:0] rise;
    logic [5:0] fall;
    logic din_s;
    logic trig_s;
    logic pin_s;

    logic wr_active_reg;
    logic [3:0] wr_cnt_reg;
    logic [`ASC_WORD_W-1:0] wr_shift_reg;
    logic [`ASC_WORD_W-1:0] wr_word_next;
    logic wr_done;
    logic addr_match;

    logic rd_armed_reg;
    logic [3:0] rd_cnt_reg;
    logic [`ASC_WORD_W-1:0] rd_shift_reg;
    logic dout_reg;
    logic dout_oe_reg;

    logic [8:0] conv_cnt_reg;
    logic [8:0] wake_cnt_reg;
    logic [`ASC_WORD_W-1:0] held_code_reg;
    logic conv_end;
    logic [1:0] pd_sel;
    logic [1:0] pd_new;

    // Two flip-flops on every pin, a third only for edge finding
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= `ASC_SYNC_IDLE;
            sync2_reg <= `ASC_SYNC_IDLE;
            sync3_reg <= `ASC_SYNC_IDLE;
        end else begin
            sync1_reg <= {package_address_pin, link.conversion_trigger, link.din,
                          link.read_frame_sync, link.write_frame_sync, link.sclk};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~sync3_reg;
    assign fall = ~sync2_reg & sync3_reg;
    assign din_s = sync2_reg[`ASC_LANE_DIN];
    assign trig_s = sync2_reg[`ASC_LANE_TRIG];
    assign pin_s = sync2_reg[`ASC_LANE_PIN];

    // Din lags by the same two flops as the clock, so it lines up with its edge
    assign wr_word_next = {wr_shift_reg[`ASC_WORD_W-2:0], din_s};
    assign wr_done = wr_active_reg && fall[`ASC_LANE_SCLK]
                     && (wr_cnt_reg == 4'(`ASC_WORD_W - 1));
    assign addr_match = (wr_word_next[`ASC_PACKAGE_ADDRESS_BIT] == pin_s);

    // Write capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_active_reg <= 1'b0;
            wr_cnt_reg <= 4'h0;
            wr_shift_reg <= `ASC_CTRL_RESET;
        end else if (fall[`ASC_LANE_WFS]) begin
            wr_active_reg <= 1'b1;
            wr_cnt_reg <= 4'h0;
        end else if (wr_active_reg && fall[`ASC_LANE_SCLK]) begin
            wr_shift_reg <= wr_word_next;
            wr_cnt_reg <= wr_cnt_reg + 4'h1;
            // Clocks after the tenth are left to fall unseen
            if (wr_done) begin
                wr_active_reg <= 1'b0;
            end
        end
    end

    // Control register and bus ownership
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_word <= `ASC_CTRL_RESET;
            selected <= 1'b0;
        end else if (wr_done) begin
            if (addr_match) begin
                ctrl_word <= wr_word_next;
                selected <= 1'b1;
            end else begin
                // Another package took this word, so it owns the next read
                selected <= 1'b0;
            end
        end
    end

    // Result readout
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_armed_reg <= 1'b0;
            rd_cnt_reg <= 4'h0;
            rd_shift_reg <= `ASC_CTRL_RESET;
            dout_reg <= 1'b0;
            dout_oe_reg <= 1'b0;
        end else if (rise[`ASC_LANE_RFS]) begin
            rd_armed_reg <= 1'b1;
            rd_cnt_reg <= 4'h0;
            rd_shift_reg <= result_word;
        end else if (rd_armed_reg && rise[`ASC_LANE_SCLK]) begin
            if (rd_cnt_reg == 4'(`ASC_READ_RELEASE)) begin
                dout_oe_reg <= 1'b0;
                rd_armed_reg <= 1'b0;
                rd_cnt_reg <= 4'h0;
            end else begin
                dout_reg <= rd_shift_reg[`ASC_WORD_W-1];
                rd_shift_reg <= {rd_shift_reg[`ASC_WORD_W-2:0], 1'b0};
                dout_oe_reg <= selected;
                rd_cnt_reg <= rd_cnt_reg + 4'h1;
            end
        end
    end

    assign link.dout = dout_reg;
    assign link.dout_oe = dout_oe_reg;

    assign conv_end = hold_active && (conv_cnt_reg == 9'h001);
    assign pd_sel = {ctrl_word[`ASC_POWER_DOWN_SELECT_HIGH],
                     ctrl_word[`ASC_POWER_DOWN_SELECT_LOW]};
    assign pd_new = {wr_word_next[`ASC_POWER_DOWN_SELECT_HIGH],
                     wr_word_next[`ASC_POWER_DOWN_SELECT_LOW]};

    // Conversion timing and track/hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_active <= 1'b0;
            conv_cnt_reg <= 9'h000;
            held_code_reg <= `ASC_CTRL_RESET;
        end else if (fall[`ASC_LANE_TRIG] && power_state == ASC_PWR_UP && !hold_active) begin
            hold_active <= 1'b1;
            held_code_reg <= sample_code;
            conv_cnt_reg <= 9'(`ASC_CONV_CYCLES);
        end else if (hold_active) begin
            conv_cnt_reg <= conv_cnt_reg - 9'h001;
            if (conv_end) begin
                hold_active <= 1'b0;
            end
        end
    end

    // Result and trigger level at conversion end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_word <= `ASC_CTRL_RESET;
            result_valid <= 1'b0;
            trigger_at_end <= 1'b1;
        end else begin
            result_valid <= conv_end;
            if (conv_end) begin
                result_word <= held_code_reg;
                trigger_at_end <= trig_s;
            end
        end
    end

    // Power control; a new word with 00 overrides the end-of-conversion choice, one with 11 only wakes a part that is down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_state <= ASC_PWR_FULL_DOWN;
            wake_cnt_reg <= 9'h000;
        end else if (wr_done && addr_match && pd_new == `ASC_PD_FULL_NOW) begin
            power_state <= ASC_PWR_FULL_DOWN;
        end else if (wr_done && addr_match && pd_new == `ASC_PD_STAY_UP
                     && power_state != ASC_PWR_UP && power_state != ASC_PWR_WAKING) begin
            power_state <= ASC_PWR_WAKING;
            wake_cnt_reg <= 9'(`ASC_POWER_UP_CYCLES);
        end else begin
            case (power_state)
                ASC_PWR_FULL_DOWN, ASC_PWR_PARTIAL_DOWN: begin
                    // A rising trigger wakes the part unless held fully down
                    if (rise[`ASC_LANE_TRIG] && pd_sel != `ASC_PD_FULL_NOW) begin
                        power_state <= ASC_PWR_WAKING;
                        wake_cnt_reg <= 9'(`ASC_POWER_UP_CYCLES);
                    end
                end
                ASC_PWR_WAKING: begin
                    wake_cnt_reg <= wake_cnt_reg - 9'h001;
                    if (wake_cnt_reg == 9'h001) begin
                        power_state <= ASC_PWR_UP;
                    end
                end
                ASC_PWR_UP: begin
                    if (conv_end && !trig_s) begin
                        case (pd_sel)
                            `ASC_PD_PARTIAL_EOC: power_state <= ASC_PWR_PARTIAL_DOWN;
                            `ASC_PD_FULL_EOC: power_state <= ASC_PWR_FULL_DOWN;
                            default: power_state <= ASC_PWR_UP;
                        endcase
                    end
                end
                default: begin
                    power_state <= ASC_PWR_FULL_DOWN;
                end
            endcase
        end
    end

endmodule : asc_device

// >>> core/asc_host.sv
// Host end: drives the shift clock, frames writes and reads, drives the trigger
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_host (
    input wire logic clk, // Core clock, 200 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    asc_link_if.host link, // Serial link to the converter
    input wire logic wr_req, // One-cycle pulse: send wr_word
    input wire logic [`ASC_WORD_W-1:0] wr_word, // Control word to send
    input wire logic use_external_ref, // Board uses external reference or supply
    input wire logic rd_req, // One-cycle pulse: read a result
    input wire logic trigger_level, // Level for the conversion trigger pin
    output logic busy, // Transfer in progress
    output logic [`ASC_WORD_W-1:0] rd_word, // Last word read
    output logic rd_valid // One-cycle pulse with rd_word
);
    import asc_pkg::*;

    asc_host_state_type state_reg;
    logic [2:0] div_reg;
    logic tick;
    logic [4:0] edge_reg;
    logic [`ASC_WORD_W-1:0] shift_reg;
    logic sclk_reg;
    logic wfs_reg;
    logic rfs_reg;
    logic din_reg;
    logic trig_reg;
    logic dline1_reg;
    logic dline2_reg;

    assign tick = (div_reg == 3'(`ASC_SCLK_HALF_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 3'h0;
        end else if (state_reg == ASC_HOST_IDLE || tick) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    // Returning data is a pin from another domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dline1_reg <= 1'b1;
            dline2_reg <= 1'b1;
            trig_reg <= 1'b1;
        end else begin
            dline1_reg <= link.dout_line;
            dline2_reg <= dline1_reg;
            trig_reg <= trigger_level;
        end
    end

    // Even edge counts are falling clock edges, odd ones rising
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ASC_HOST_IDLE;
            edge_reg <= 5'h00;
            shift_reg <= `ASC_CTRL_RESET;
            sclk_reg <= 1'b1;
            wfs_reg <= 1'b1;
            rfs_reg <= 1'b0;
            din_reg <= 1'b0;
            rd_word <= `ASC_CTRL_RESET;
            rd_valid <= 1'b0;
            busy <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            case (state_reg)
                ASC_HOST_IDLE: begin
                    edge_reg <= 5'h00;
                    if (wr_req) begin
                        state_reg <= ASC_HOST_WRITE;
                        busy <= 1'b1;
                        wfs_reg <= 1'b0;
                        // Bit 0 forced when the board reference is not internal
                        shift_reg <= {wr_word[`ASC_WORD_W-1:1],
                                      wr_word[0] | use_external_ref};
                        din_reg <= wr_word[`ASC_WORD_W-1];
                    end else if (rd_req) begin
                        state_reg <= ASC_HOST_READ;
                        busy <= 1'b1;
                        rfs_reg <= 1'b1;
                    end
                end
                ASC_HOST_WRITE: begin
                    if (tick) begin
                        sclk_reg <= ~sclk_reg;
                        edge_reg <= edge_reg + 5'h01;
                        if (edge_reg[0]) begin
                            // Rising edge: present the next bit, zeros after ten
                            shift_reg <= {shift_reg[`ASC_WORD_W-2:0], 1'b0};
                            din_reg <= shift_reg[`ASC_WORD_W-2];
                        end
                        if (edge_reg == 5'(2 * `ASC_WRITE_CLOCKS - 1)) begin
                            state_reg <= ASC_HOST_IDLE;
                            busy <= 1'b0;
                            wfs_reg <= 1'b1;
                            din_reg <= 1'b0;
                        end
                    end
                end
                ASC_HOST_READ: begin
                    if (tick) begin
                        sclk_reg <= ~sclk_reg;
                        edge_reg <= edge_reg + 5'h01;
                        // Falling edges after rises 1..10 carry bits, first is MSB
                        if (!edge_reg[0] && edge_reg != 5'h00) begin
                            shift_reg <= {shift_reg[`ASC_WORD_W-2:0], dline2_reg};
                        end
                        if (edge_reg == 5'(2 * `ASC_READ_RELEASE + 1)) begin
                            state_reg <= ASC_HOST_IDLE;
                            busy <= 1'b0;
                            rfs_reg <= 1'b0;
                            rd_word <= shift_reg;
                            rd_valid <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_reg <= ASC_HOST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    assign link.sclk = sclk_reg;
    assign link.write_frame_sync = wfs_reg;
    assign link.read_frame_sync = rfs_reg;
    assign link.din = din_reg;
    assign link.conversion_trigger = trig_reg;

endmodule : asc_host

// >>> bench/asc_link_props.sv
// Concurrent checks on the serial link between host and converter ends
`timescale 1ns/1ps
module asc_link_props (
    input wire logic clk, // Core clock
    input wire logic rst_n, // Reset, active low
    input wire logic sclk, // Shift clock
    input wire logic write_frame_sync, // Write framing
    input wire logic read_frame_sync, // Read framing
    input wire logic din, // Host to device data
    input wire logic dout, // Device data
    input wire logic dout_oe, // Device drives the line
    input wire logic conversion_trigger, // Trigger pin
    input wire logic dout_line // Resolved data line
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic sclk_q;
    logic [3:0] wr_falls;
    logic [3:0] rd_rises;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b1;
        end else begin
            sclk_q <= sclk;
        end
    end

    // Counts restart with every frame so a short frame cannot hide behind an old count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_falls <= 4'h0;
        end else if (write_frame_sync) begin
            wr_falls <= 4'h0;
        end else if (!sclk && sclk_q) begin
            wr_falls <= wr_falls + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_rises <= 4'h0;
        end else if (!read_frame_sync) begin
            rd_rises <= 4'h0;
        end else if (sclk && !sclk_q) begin
            rd_rises <= rd_rises + 4'h1;
        end
    end

    sclk_idle_a: assert property ((write_frame_sync && !read_frame_sync) |-> sclk)
        else $error("shift clock not idle outside frames");
    din_timing_a: assert property ($changed(din) |-> sclk)
        else $error("serial input changed while shift clock low");
    dout_timing_a: assert property ((dout_oe && $past(dout_oe) && $changed(dout)) |-> sclk)
        else $error("serial output changed while shift clock low");
    oe_release_a: assert property ($fell(read_frame_sync) |-> ##[1:8] !dout_oe)
        else $error("serial output not released after read");
    oe_start_a: assert property ($rose(dout_oe) |-> read_frame_sync)
        else $error("serial output driven outside a read frame");
    wr_count_a: assert property ($rose(write_frame_sync) |-> wr_falls == 4'hD)
        else $error("write frame without thirteen clock falls");
    rd_count_a: assert property ($fell(read_frame_sync) |-> rd_rises == 4'hA && sclk && !sclk_q)
        else $error("read frame not ended on eleventh rise");
    wr_frame_a: assert property ($fell(write_frame_sync) |-> ##[200:215] write_frame_sync)
        else $error("write frame length wrong");
endmodule : asc_link_props

// >>> bench/test_adc_serial_control_port.sv
// Self-checking bench joining host and converter ends over the serial link
`timescale 1ns/1ps
`include "asc_consts.svh"
module test_adc_serial_control_port;
    import asc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin = 1'b0;
    logic [9:0] sample_code = 10'h000;
    logic wr_req = 1'b0;
    logic [9:0] wr_word = 10'h000;
    logic use_external_ref = 1'b0;
    logic rd_req = 1'b0;
    logic trigger_level = 1'b1;
    logic [9:0] ctrl_word, result_word, rd_word, word, code, got;
    logic selected, hold_active, result_valid, trigger_at_end, busy, rd_valid;
    asc_pwr_type power_state;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    int hold_len = 0;
    // Stay-up first: only that code wakes the part from its reset state
    logic [1:0] pd_tab [4] = '{2'h3, 2'h1, 2'h2, 2'h1};
    logic hi_tab [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

    always #2.5 clk = ~clk;

    asc_link_if i_asc_link_if ();
    asc_device i_asc_device (.clk(clk), .rst_n(rst_n), .link(i_asc_link_if.dev),
        .package_address_pin(pin), .sample_code(sample_code), .ctrl_word(ctrl_word),
        .selected(selected), .power_state(power_state), .hold_active(hold_active),
        .result_valid(result_valid), .result_word(result_word),
        .trigger_at_end(trigger_at_end));
    asc_host i_asc_host (.clk(clk), .rst_n(rst_n), .link(i_asc_link_if.host),
        .wr_req(wr_req), .wr_word(wr_word), .use_external_ref(use_external_ref),
        .rd_req(rd_req), .trigger_level(trigger_level), .busy(busy), .rd_word(rd_word),
        .rd_valid(rd_valid));
    asc_link_props i_asc_link_props (.clk(clk), .rst_n(rst_n), .sclk(i_asc_link_if.sclk),
        .write_frame_sync(i_asc_link_if.write_frame_sync),
        .read_frame_sync(i_asc_link_if.read_frame_sync), .din(i_asc_link_if.din),
        .dout(i_asc_link_if.dout), .dout_oe(i_asc_link_if.dout_oe),
        .conversion_trigger(i_asc_link_if.conversion_trigger),
        .dout_line(i_asc_link_if.dout_line));

    task end_sim;
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task check(input string name, input logic [9:0] exp, input logic [9:0] seen);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function asc_pwr_type pwr_exp(input logic [1:0] pd, input logic hi);
        if (hi || pd == `ASC_PD_STAY_UP) return ASC_PWR_UP;
        if (pd == `ASC_PD_PARTIAL_EOC) return ASC_PWR_PARTIAL_DOWN;
        return ASC_PWR_FULL_DOWN;
    endfunction : pwr_exp

    task send(input logic [9:0] w, input logic ext);
        @(posedge clk);
        wr_req <= 1'b1;
        wr_word <= w;
        use_external_ref <= ext;
        @(posedge clk);
        wr_req <= 1'b0;
        @(negedge clk);
        while (busy !== 1'b0) @(negedge clk);
        repeat (8) @(negedge clk);
    endtask : send

    task read(output logic [9:0] w);
        @(posedge clk);
        rd_req <= 1'b1;
        @(posedge clk);
        rd_req <= 1'b0;
        @(negedge clk);
        while (rd_valid !== 1'b1) @(negedge clk);
        w = rd_word;
    endtask : read

    // A hang anywhere ends the run as a failure
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end

    // Every conversion must hold the sample for exactly the conversion time
    always @(negedge clk) begin
        if (hold_active === 1'b1) begin
            hold_len++;
        end else if (hold_len != 0) begin
            check("hold_len", 10'(`ASC_CONV_CYCLES), 10'(hold_len));
            hold_len = 0;
        end
    end

    initial begin
        void'($urandom(15954));
        pin <= 1'($urandom);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("ctrl_word", `ASC_CTRL_RESET, ctrl_word);
        check("selected", 10'h000, selected);
        check("power_state", ASC_PWR_FULL_DOWN, power_state);
        for (int i = 0; i < 4; i++) begin
            word = {1'b0, pin, pd_tab[i], 5'($urandom), 1'b0};
            send(word, 1'(i));
            check("ctrl_word", word | 10'(i % 2), ctrl_word);
            check("selected", 10'h001, selected);
            while (power_state !== ASC_PWR_UP) @(negedge clk);
            code = 10'($urandom);
            @(posedge clk);
            sample_code <= code;
            trigger_level <= 1'b0;
            @(negedge clk);
            while (hold_active !== 1'b1) @(negedge clk);
            @(posedge clk);
            sample_code <= ~code;
            repeat (10) @(posedge clk);
            trigger_level <= hi_tab[i];
            while (result_valid !== 1'b1) @(negedge clk);
            check("result_word", code, result_word);
            check("trigger_at_end", 10'(hi_tab[i]), trigger_at_end);
            repeat (3) @(negedge clk);
            check("power_state", pwr_exp(pd_tab[i], hi_tab[i]), power_state);
            @(posedge clk);
            trigger_level <= 1'b1;
            for (int k = 0; k < 2; k++) begin
                read(got);
                check("rd_word", code, got);
            end
        end
        word = {1'b0, pin, `ASC_PD_FULL_NOW, 6'h2A};
        send(word, 1'b0);
        check("power_state", ASC_PWR_FULL_DOWN, power_state);
        send({1'b0, ~pin, `ASC_PD_STAY_UP, 6'h15}, 1'b0);
        check("ctrl_word", word, ctrl_word);
        check("selected", 10'h000, selected);
        read(got);
        check("rd_word", 10'h3FF, got);
        end_sim();
    end
endmodule : test_adc_serial_control_port
